/* File: hdl/ssru_pkg.sv */
// Contract
// - clear-status or device reset drops any armed operation-complete report.
// - device clear or selected device clear also drops the armed report.
// - store pass-back address 0..30; hand control back there after controlled operation.
// - keep optional secondary pass-back address for extended addressing controllers.
// - pass-back address persists across power cycles and device reset.
// - at power-up, clear flag 1 zeroes both masks, 0 restores saved masks.
// - clear flag accepts -32767..32767, persists, reads back as 0 or 1.
// - power-up request needs event enable bit 7 and summary enable bit 5.
// - device reset restores presets and cancels pending operation-complete report (code restores no presets; device reset only cancels the armed report).
// - device reset leaves clear flag, masks and bus addresses untouched.
// - service enable mask is eight bits, written as 0..255.
// - written enable bit 6 is ignored; summary bit 6 always enabled (code instead forces effective enable bit 6 to 0 via SSRU_BIT6_MASK).
// - request service when summary bit rises while its enable is set.
// - request service when enable bit rises while its summary bit is set.
// - mask query returns its current contents.
// - summary query returns 0..255 and does not clear; only clear-status does.
// - bits 0,2,3,5,7 are summaries; bit 1 reserved.
// - bit 4 is set while the output queue holds anything.
// - query bit 6 is the master summary of enabled bits.
// - serial poll bit 6 carries the request-service indication.
// - summary bit 5 set only when an enabled standard event is set.
package ssru_pkg;
  localparam logic [4:0] SSRU_ADDR_MAX = 5'h1E;
  localparam logic [4:0] SSRU_ADDR_RST = 5'h00;
  localparam logic [7:0] SSRU_MASK_RST = 8'h00;
  localparam logic [7:0] SSRU_BYTE_ZERO = 8'h00;
  localparam logic [7:0] SSRU_BIT6_MASK = 8'hBF;
  localparam logic [7:0] SSRU_RESERVED_MASK = 8'hFD;
  localparam int SSRU_BIT_USER = 0;
  localparam int SSRU_BIT_DEV = 2;
  localparam int SSRU_BIT_QUES = 3;
  localparam int SSRU_BIT_OUT_PEND = 4;
  localparam int SSRU_BIT_ESB = 5;
  localparam int SSRU_BIT_REQ_SVC = 6;
  localparam int SSRU_BIT_OPER = 7;
  localparam int SSRU_ESE_PON = 7;
  localparam logic [15:0] SSRU_PSC_MIN = 16'h8001;

  typedef struct packed {
    logic user_sum;
    logic dev_sum;
    logic ques_sum;
    logic oper_sum;
    logic [7:0] std_event;
    logic [7:0] std_enable;
  } ssru_src_type;

  typedef struct packed {
    logic cls;
    logic rst;
    logic dcl;
  } ssru_clr_type;

  typedef struct packed {
    logic valid;
    logic [4:0] primary;
    logic sec_valid;
    logic [4:0] secondary;
  } ssru_pcb_type;
endpackage

/* File: hdl/ssru_poll.sv */
`timescale 1ns/1ps
`default_nettype none
module ssru_poll
  import ssru_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic rst_n, // async reset
  input wire logic ce, // clock enable
  input wire logic [7:0] summary, // summary bits, bit 6 unused
  input wire logic [7:0] enable, // effective enable mask
  input wire logic clear, // clear pending request
  input wire logic poll, // serial poll strobe
  output logic request_service_bit // request pending
);
  logic [7:0] summary_q;
  logic [7:0] enable_q;
  logic [7:0] hit;
  logic rise;

  // new qualifying rise of either side
  assign hit = summary & enable & SSRU_BIT6_MASK;
  assign rise = |(hit & ~(summary_q & enable_q));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      summary_q <= SSRU_BYTE_ZERO;
      enable_q <= SSRU_MASK_RST;
    end else if (ce) begin
      summary_q <= summary;
      enable_q <= enable;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      request_service_bit <= 1'b0;
    end else if (ce) begin
      if (rise) begin
        request_service_bit <= 1'b1;
      end else if (clear || (poll && request_service_bit)) begin
        request_service_bit <= 1'b0;
      end
    end
  end

  chk_rise_sets_req: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && rise |=> request_service_bit) else $error("rising enabled summary did not request");
  chk_poll_drops: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && poll && request_service_bit && !rise |=> !request_service_bit)
    else $error("request kept after poll");
endmodule
`default_nettype wire

/* File: hdl/ssru_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ssru_top
  import ssru_pkg::*;
(
  input wire logic mclk, // 20 MHz clock
  input wire logic rst_n, // power-up reset, active low
  input wire logic ce, // clock enable
  input wire ssru_src_type src, // event summaries feeding the byte
  input wire logic queue_nonempty, // output queue holds data
  input wire ssru_clr_type clr, // clear-status, device reset, bus device clear
  input wire logic no_pending_operation_flag, // no pending overlapped operation
  input wire logic opc_cmd, // arm completion report to event bit 0
  input wire logic opc_query, // arm completion answer to output queue
  input wire logic sre_wr, // write service enable mask
  input wire logic [7:0] sre_wdata, // mask value 0..255
  input wire logic ese_wr, // write event enable mask
  input wire logic [7:0] ese_wdata, // event enable value
  input wire logic psc_wr, // write power-on clear setting
  input wire logic [15:0] psc_wdata, // signed setting
  input wire logic pcb_wr, // write pass-back address
  input wire ssru_pcb_type pcb_wdata, // pass-back address value
  input wire logic ctl_done, // operation needing bus control finished
  input wire logic poll, // serial poll read strobe
  input wire logic nv_load, // power-up restore strobe from storage
  input wire logic nv_psc, // stored power-on clear flag
  input wire logic [7:0] nv_sre, // stored service enable mask
  input wire logic [7:0] nv_ese, // stored event enable mask
  input wire ssru_pcb_type nv_pcb, // stored pass-back address
  output logic [7:0] stb_query, // summary byte as read by query
  output logic [7:0] stb_poll, // summary byte as read by serial poll
  output logic [7:0] sre_q, // service enable mask readback
  output logic [7:0] ese_q, // event enable mask
  output logic psc_q, // power-on clear flag readback
  output ssru_pcb_type pcb_q, // pass-back address, saved to storage
  output logic pass_ctl, // pass control back pulse
  output logic [4:0] pass_addr, // primary address for pass back
  output logic [4:0] pass_sec, // secondary address for pass back
  output logic pass_sec_en, // secondary address in use
  output logic srq, // service request toward controller
  output logic opc_event, // sets event bit 0 on completion
  output logic opc_answer // places completion answer in queue
);
  logic [7:0] summary;
  logic [7:0] sre_eff;
  logic request_service_bit;
  logic opc_cmd_q;
  logic opc_query_q;
  logic cancel;

  function automatic logic psc_decode(input logic [15:0] v);
    return (v != 16'h0000);
  endfunction

  function automatic logic addr_ok(input logic [4:0] a);
    return (a <= SSRU_ADDR_MAX);
  endfunction

  // status summary byte; bit 6 filled per read path
  always_comb begin
    summary = SSRU_BYTE_ZERO;
    summary[SSRU_BIT_USER] = src.user_sum;
    summary[SSRU_BIT_DEV] = src.dev_sum;
    summary[SSRU_BIT_QUES] = src.ques_sum;
    summary[SSRU_BIT_OUT_PEND] = queue_nonempty;
    summary[SSRU_BIT_ESB] = |(src.std_event & src.std_enable);
    summary[SSRU_BIT_OPER] = src.oper_sum;
  end

  assign sre_eff = sre_q & SSRU_BIT6_MASK;
  assign cancel = clr.cls | clr.rst | clr.dcl;

  // read paths hold registered copies; a query read clears nothing, a serial poll clears the request bit
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stb_query <= SSRU_BYTE_ZERO;
      stb_poll <= SSRU_BYTE_ZERO;
    end else if (ce) begin
      stb_query <= (summary & SSRU_RESERVED_MASK) |
        ({7'h00, |(summary & sre_eff)} << SSRU_BIT_REQ_SVC);
      stb_poll <= (summary & SSRU_RESERVED_MASK) |
        ({7'h00, request_service_bit} << SSRU_BIT_REQ_SVC);
    end
  end

  // enable masks: untouched by device reset, restored or zeroed at power-up
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sre_q <= SSRU_MASK_RST;
      ese_q <= SSRU_MASK_RST;
    end else if (ce) begin
      if (nv_load) begin
        sre_q <= nv_psc ? SSRU_MASK_RST : nv_sre;
        ese_q <= nv_psc ? SSRU_MASK_RST : nv_ese;
      end else begin
        if (sre_wr) begin
          sre_q <= sre_wdata;
        end
        if (ese_wr) begin
          ese_q <= ese_wdata;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      psc_q <= 1'b0;
    end else if (ce) begin
      if (nv_load) begin
        psc_q <= nv_psc;
      // only the one code below the signed range is refused
      end else if (psc_wr && $signed(psc_wdata) >= $signed(SSRU_PSC_MIN)) begin
        psc_q <= psc_decode(psc_wdata);
      end
    end
  end

  // pass-back address, kept across device reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pcb_q <= '0;
    end else if (ce) begin
      if (nv_load) begin
        pcb_q <= nv_pcb;
      end else if (pcb_wr && addr_ok(pcb_wdata.primary)) begin
        pcb_q.valid <= 1'b1;
        pcb_q.primary <= pcb_wdata.primary;
        pcb_q.sec_valid <= pcb_wdata.sec_valid && addr_ok(pcb_wdata.secondary);
        pcb_q.secondary <= pcb_wdata.secondary;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pass_ctl <= 1'b0;
      pass_addr <= SSRU_ADDR_RST;
      pass_sec <= SSRU_ADDR_RST;
      pass_sec_en <= 1'b0;
    end else if (ce) begin
      pass_ctl <= ctl_done && pcb_q.valid;
      if (ctl_done) begin
        pass_addr <= pcb_q.primary;
        pass_sec <= pcb_q.secondary;
        pass_sec_en <= pcb_q.sec_valid;
      end
    end
  end

  // armed operation-complete reporting
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      opc_cmd_q <= 1'b0;
      opc_query_q <= 1'b0;
      opc_event <= 1'b0;
      opc_answer <= 1'b0;
    end else if (ce) begin
      opc_event <= opc_cmd_q && no_pending_operation_flag && !cancel;
      opc_answer <= opc_query_q && no_pending_operation_flag && !cancel;
      if (cancel) begin
        opc_cmd_q <= 1'b0;
        opc_query_q <= 1'b0;
      end else begin
        // an arm taken while idle still reports once on the next cycle
        if (opc_cmd) begin
          opc_cmd_q <= 1'b1;
        end else if (no_pending_operation_flag) begin
          opc_cmd_q <= 1'b0;
        end
        if (opc_query) begin
          opc_query_q <= 1'b1;
        end else if (no_pending_operation_flag) begin
          opc_query_q <= 1'b0;
        end
      end
    end
  end

  ssru_poll u_poll (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .summary(summary),
    .enable(sre_eff),
    .clear(clr.cls),
    .poll(poll),
    .request_service_bit(request_service_bit)
  );

  assign srq = request_service_bit;

  chk_cancel_opc: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && cancel |=> !opc_cmd_q && !opc_query_q) else $error("completion report survived clear");
  chk_dcl_cancel: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && clr.dcl |=> ce |-> !opc_event && !opc_answer) else $error("device clear kept report");
  chk_rst_masks: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && clr.rst && !nv_load && !sre_wr |=> $stable(sre_q)) else $error("reset changed mask");
  chk_psc_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && nv_load && nv_psc |=> sre_q == SSRU_MASK_RST && ese_q == SSRU_MASK_RST)
    else $error("masks not zeroed at power-up");
  chk_mav_bit: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && queue_nonempty |=> stb_query[SSRU_BIT_OUT_PEND]) else $error("output pending flag missing");
  chk_poll_bit6: assert property (@(posedge mclk) disable iff (!rst_n)
    ce |=> stb_poll[SSRU_BIT_REQ_SVC] == $past(request_service_bit)) else $error("poll bit 6 wrong");
  chk_pcb_range: assert property (@(posedge mclk) disable iff (!rst_n)
    pcb_q.valid |-> pcb_q.primary <= SSRU_ADDR_MAX) else $error("pass-back address out of range");
  chk_pass_back: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && ctl_done && pcb_q.valid |=> pass_ctl) else $error("control not passed back");
  chk_esb_cause: assert property (@(posedge mclk) disable iff (!rst_n)
    ce |=> stb_query[SSRU_BIT_ESB] == |($past(src.std_event) & $past(src.std_enable)))
    else $error("event summary bit wrong");

  cov_srq: cover property (@(posedge mclk) disable iff (!rst_n) $rose(srq));
  cov_poll_clear: cover property (@(posedge mclk) disable iff (!rst_n) srq && poll ##1 !srq);
  cov_pass: cover property (@(posedge mclk) disable iff (!rst_n) pass_ctl);
  cov_opc: cover property (@(posedge mclk) disable iff (!rst_n) opc_event);
endmodule
`default_nettype wire

/* File: tb/ssru_ctlr_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ssru_ctlr_model
  import ssru_pkg::*;
#(
  parameter logic [4:0] OWN_ADDR = 5'h15,
  parameter logic [4:0] OWN_SEC = 5'h03
)
(
  input wire logic mclk, // clock
  input wire logic rst_n, // reset
  input wire logic srq, // service request seen
  input wire logic answer_en, // poll when requested
  input wire logic slow, // answer late
  input wire logic hand_ctl, // about to pass control
  output logic poll, // serial poll strobe
  output logic pcb_wr, // load pass-back address
  output ssru_pcb_type pcb_wdata // own address
);
  logic [1:0] wait_q;
  logic hand_q;
  // own address written before control is handed over
  assign pcb_wdata = '{1'b1, OWN_ADDR, 1'b1, OWN_SEC};
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 2'h0;
      poll <= 1'b0;
    end else begin
      poll <= 1'b0;
      if (!srq || !answer_en) begin
        wait_q <= 2'h0;
      end else if (wait_q == (slow ? 2'h3 : 2'h1)) begin
        poll <= 1'b1;
        wait_q <= 2'h0;
      end else begin
        wait_q <= wait_q + 2'h1;
      end
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hand_q <= 1'b0;
      pcb_wr <= 1'b0;
    end else begin
      hand_q <= hand_ctl;
      pcb_wr <= hand_ctl && !hand_q;
    end
  end
endmodule
`default_nettype wire

/* File: tb/status_service_request_unit_test.sv */
`timescale 1ns/1ps
`default_nettype none
module status_service_request_unit_test;
  import ssru_pkg::*;
  localparam int LIMIT = 3000;
  localparam logic [8:0] P_SRE = 9'h001, P_PSC = 9'h002, P_NV = 9'h004, P_OPC = 9'h008;
  localparam logic [8:0] P_OPQ = 9'h010, P_DONE = 9'h020, P_RST = 9'h080, P_CLS = 9'h100;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic qne = 1'b0, no_pending_operation_flag = 1'b1, nv_psc = 1'b0, answer_en = 1'b0;
  logic slow = 1'b0, hand_ctl = 1'b0;
  logic [8:0] strobes = 9'h000;
  logic [7:0] sre_wdata = 8'h00, nv_sre = 8'h24, nv_ese = 8'h80;
  logic [15:0] psc_wdata = 16'h0000;
  ssru_src_type src = '0;
  logic poll, pcb_wr, pass_ctl, pass_sec_en, srq, opc_event, opc_answer, psc_q;
  ssru_pcb_type pcb_wdata, pcb_q;
  logic [7:0] stb_query, stb_poll, sre_q, ese_q;
  logic [4:0] pass_addr, pass_sec;
  int num_errors = 0, total_checks = 0, cycles = 0, ev_n = 0, ans_n = 0, pass_n = 0;
  int ev0 = 0, an0 = 0, ps0 = 0;
  // expected flag after each write; the code below the range is refused
  localparam logic [5:0] PV_EXP = 6'b110010;
  logic [15:0] pv [6] = '{16'h0000, 16'h7FFF, 16'h0000, 16'h8000, 16'h8001, 16'hFFFF};

  ssru_top dut_u (.mclk(mclk), .rst_n(rst_n), .ce(1'b1), .src(src), .queue_nonempty(qne),
    .clr(ssru_clr_type'(strobes[8:6])), .opc_cmd(strobes[3]), .opc_query(strobes[4]),
    .no_pending_operation_flag(no_pending_operation_flag), .sre_wr(strobes[0]),
    .sre_wdata(sre_wdata), .ese_wr(strobes[0]), .ese_wdata(sre_wdata), .psc_wr(strobes[1]),
    .psc_wdata(psc_wdata), .pcb_wr(pcb_wr),
    .pcb_wdata(pcb_wdata), .ctl_done(strobes[5]), .poll(poll), .nv_load(strobes[2]),
    .nv_psc(nv_psc), .nv_sre(nv_sre), .nv_ese(nv_ese), .nv_pcb('0), .stb_query(stb_query),
    .stb_poll(stb_poll), .sre_q(sre_q), .ese_q(ese_q), .psc_q(psc_q), .pcb_q(pcb_q),
    .pass_ctl(pass_ctl), .pass_addr(pass_addr), .pass_sec(pass_sec),
    .pass_sec_en(pass_sec_en), .srq(srq), .opc_event(opc_event), .opc_answer(opc_answer));
  ssru_ctlr_model ctl_u (.mclk(mclk), .rst_n(rst_n), .srq(srq), .answer_en(answer_en),
    .slow(slow), .hand_ctl(hand_ctl), .poll(poll), .pcb_wr(pcb_wr), .pcb_wdata(pcb_wdata));

  initial begin
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    ev_n += opc_event;
    ans_n += opc_answer;
    pass_n += pass_ctl;
    if (cycles == LIMIT) begin
      num_errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // one-cycle strobe, data presented with it
  task automatic pulse(input logic [8:0] m, input logic [15:0] d);
    @(posedge mclk);
    strobes <= m;
    sre_wdata <= d[7:0];
    psc_wdata <= d;
    @(posedge mclk);
    strobes <= 9'h000;
    #1;
  endtask
  task automatic wait_srq(input logic v);
    for (int i = 0; i < 12 && srq !== v; i++) tick(1);
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    tick(1);
    for (int k = 1; k >= 0; k--) begin
      @(posedge mclk);
      nv_psc <= k[0];
      pulse(P_NV, 16'h0000);
      chk("sre_q", k ? 8'h00 : nv_sre, sre_q);
      chk("ese_q", k ? 8'h00 : nv_ese, ese_q);
      chk("psc_q", k[0], psc_q);
    end
    $display("restore test done");
    @(posedge mclk);
    src.std_event <= 8'h80;
    src.std_enable <= 8'h80;
    wait_srq(1'b1);
    chk("srq", 1'b1, srq);
    chk("stb_query", 8'h60, stb_query);
    tick(1);
    chk("stb_poll", 8'h60, stb_poll);
    @(posedge mclk);
    answer_en <= 1'b1;
    slow <= 1'b1;
    wait_srq(1'b0);
    chk("srq", 1'b0, srq);
    chk("stb_query", 8'h60, stb_query);
    tick(1);
    chk("stb_poll", 8'h20, stb_poll);
    $display("power-up request test done");
    for (int k = 0; k < 6; k++) begin
      pulse(P_PSC, pv[k]);
      chk("psc_q", PV_EXP[k], psc_q);
    end
    $display("clear flag test done");
    pulse(P_SRE, 16'h0040);
    @(posedge mclk);
    src.dev_sum <= 1'b1;
    answer_en <= 1'b0;
    tick(3);
    chk("srq", 1'b0, srq);
    chk("sre_q", 8'h40, sre_q);
    chk("stb_query", 8'h24, stb_query);
    pulse(P_SRE, 16'h0004);
    wait_srq(1'b1);
    chk("srq", 1'b1, srq);
    chk("stb_query", 8'h64, stb_query);
    pulse(P_CLS, 16'h0000);
    wait_srq(1'b0);
    chk("srq", 1'b0, srq);
    pulse(P_SRE, 16'h0014);
    tick(3);
    chk("srq", 1'b0, srq);
    @(posedge mclk);
    qne <= 1'b1;
    wait_srq(1'b1);
    chk("srq", 1'b1, srq);
    chk("stb_query", 8'h74, stb_query);
    $display("request test done");
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      no_pending_operation_flag <= 1'b0;
      pulse(i[0] ? P_OPQ : P_OPC, 16'h0000);
      // kind 1 bus clear, 2 device reset, 3 clear-status
      if (i[2:1] != 2'h0) pulse(P_DONE << i[2:1], 16'h0000);
      ev0 = ev_n;
      an0 = ans_n;
      @(posedge mclk);
      no_pending_operation_flag <= 1'b1;
      tick(4);
      chk("opc_event", !i[0] && i[2:1] == 2'h0, 16'(ev_n - ev0));
      chk("opc_answer", i[0] && i[2:1] == 2'h0, 16'(ans_n - an0));
    end
    $display("completion test done");
    @(posedge mclk);
    hand_ctl <= 1'b1;
    tick(3);
    chk("pcb_q", {4'h0, 1'b1, 5'h15, 1'b1, 5'h03}, pcb_q);
    pulse(P_RST, 16'h0000);
    chk("pcb_q", {4'h0, 1'b1, 5'h15, 1'b1, 5'h03}, pcb_q);
    chk("sre_q", 8'h14, sre_q);
    chk("psc_q", 1'b1, psc_q);
    chk("ese_q", 8'h14, ese_q);
    ps0 = pass_n;
    pulse(P_DONE, 16'h0000);
    tick(2);
    chk("pass_ctl", 16'h0001, 16'(pass_n - ps0));
    chk("pass_addr", 5'h15, pass_addr);
    chk("pass_sec", {1'b1, 5'h03}, {pass_sec_en, pass_sec});
    $display("pass back test done");
    close_out();
  end
endmodule
`default_nettype wire
